// ---- src/rrx_map.vh ----
/*
 * register offsets, fields, opcodes and cycle counts of the
 * return and rotate execution block.
 * assumes inclusion by bare name from the rrx design files.
 */
`ifndef RRX_MAP_VH
`define RRX_MAP_VH

// ==========================================================
// register byte offsets
`define RRX_REG_CMD 8'h00
`define RRX_REG_STATUS 8'h04
`define RRX_REG_ACC 8'h08
`define RRX_REG_CARRY 8'h0C
`define RRX_REG_IRQCTL 8'h10
`define RRX_REG_PC 8'h14
`define RRX_REG_POINTER 8'h18
`define RRX_REG_PUSH 8'h1C
`define RRX_REG_FILE 8'h20

// ==========================================================
// decoded register indexes
`define RRX_IX_CMD 4'h0
`define RRX_IX_STATUS 4'h1
`define RRX_IX_ACC 4'h2
`define RRX_IX_CARRY 4'h3
`define RRX_IX_IRQCTL 4'h4
`define RRX_IX_PC 4'h5
`define RRX_IX_POINTER 4'h6
`define RRX_IX_PUSH 4'h7
`define RRX_IX_FILE 4'h8
`define RRX_IX_NONE 4'hF

// ==========================================================
// command word fields
`define RRX_F_OP 2:0
`define RRX_F_DEST 3
`define RRX_F_PCCHG 4
`define RRX_F_COND 5
`define RRX_F_IND 6
`define RRX_F_FADDR 14:8
`define RRX_F_LIT 23:16

// file window fields
`define RRX_F_WADDR 14:8
`define RRX_F_WDATA 7:0

// status fields
`define RRX_S_BUSY 0
`define RRX_S_NOP 1
`define RRX_S_CYC 10:8
`define RRX_S_SP 23:16

// ==========================================================
// operations
`define RRX_OP_RETURN_FROM_IRQ 3'h0
`define RRX_OP_RETURN 3'h1
`define RRX_OP_RETURN_WITH_LITERAL 3'h2
`define RRX_OP_ROTATE 3'h3
`define RRX_OP_GENERIC 3'h4

// ==========================================================
// bits, cycle counts, reset values
`define RRX_GIE_BIT 7
`define RRX_PTR_MSB 7
`define RRX_INDIRECT_ADDR 7'h00
`define RRX_CYC_ONE 3'h1
`define RRX_CYC_TWO 3'h2
`define RRX_RESP_OKAY 2'h0
`define RRX_RESP_SLVERR 2'h2
`define RRX_ZERO32 32'h0000_0000

`endif

// ---- src/rrx_stack.v ----
/*
 * return address stack held in flip-flops, push and pop.
 * assumes the caller never pushes and pops in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module rrx_stack #(
	parameter DEPTH = 16,
	parameter SP_W = 4,
	parameter AW = 15
) (
	input wire aclk,
	input wire aresetn,
	input wire push,
	input wire [AW-1:0] push_data,
	input wire pop,
	output wire [AW-1:0] top,
	output wire [SP_W-1:0] sp
);

	reg [AW-1:0] mem [0:DEPTH-1];
	reg [SP_W-1:0] ptr;
	wire [SP_W-1:0] top_ix;

	assign top_ix = ptr - {{(SP_W-1){1'b0}}, 1'b1};
	assign top = mem[top_ix];
	assign sp = ptr;

	// ==========================================================
	// pointer and storage
	always @(posedge aclk) begin
		if (!aresetn) begin
			ptr <= {SP_W{1'b0}};
		end else if (pop) begin
			ptr <= top_ix;
		end else if (push) begin
			mem[ptr] <= push_data;
			ptr <= ptr + {{(SP_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// ---- src/rrx_file.v ----
/*
 * bank of file registers in flip-flops, one write port and
 * two read ports.
 * assumes writes come from one owner per cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module rrx_file #(
	parameter DEPTH = 128,
	parameter ADDR_W = 7
) (
	input wire aclk,
	input wire we,
	input wire [ADDR_W-1:0] waddr,
	input wire [7:0] wdata,
	input wire [ADDR_W-1:0] raddr_a,
	output wire [7:0] rdata_a,
	input wire [ADDR_W-1:0] raddr_b,
	output wire [7:0] rdata_b
);

	reg [7:0] mem [0:DEPTH-1];

	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];

	// ==========================================================
	// write port
	always @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

endmodule

`default_nettype wire

// ---- src/rrx_exec.v ----
/*
 * return and rotate execution core with an axi4-lite register
 * slave, instruction-cycle divider, stack and file registers.
 * assumes one axi master and a single clock.
 */
// What this block does
// - an instruction that changes the pc or has a true test takes two cycles.
// - that second cycle runs as a no-operation with no side effects.
// - an indirect access with the pointer top bit set adds one cycle.
// - return from irq pops the stack into the pc, one word, no operands.
// - return from irq sets the global irq enable, bit 7 of irq control.
// - return from irq takes exactly two cycles and keeps all flags.
// - return pops the stack into the pc in two cycles, flags kept.
// - return with literal loads its 8-bit literal into the accumulator.
// - return with literal also loads the pc from the stack in two cycles.
// - rotate left shifts through carry, old carry into bit zero.
// - rotate destination 0 writes the accumulator, 1 the file register.
// - rotate takes a file address 0 to 127 and runs in one cycle, two if indirect with the pointer top bit set.
`timescale 1ns/10ps
`default_nettype none
`include "rrx_map.vh"

module rrx_exec #(
	parameter CYC_DIV = 4,
	parameter PC_W = 15,
	parameter STACK_DEPTH = 16,
	parameter SP_W = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	localparam [7:0] DIV_LAST = CYC_DIV - 1;

	// ==========================================================
	// address decode and byte-lane merge
	function [3:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
			`RRX_REG_CMD: reg_index = `RRX_IX_CMD;
			`RRX_REG_STATUS: reg_index = `RRX_IX_STATUS;
			`RRX_REG_ACC: reg_index = `RRX_IX_ACC;
			`RRX_REG_CARRY: reg_index = `RRX_IX_CARRY;
			`RRX_REG_IRQCTL: reg_index = `RRX_IX_IRQCTL;
			`RRX_REG_PC: reg_index = `RRX_IX_PC;
			`RRX_REG_POINTER: reg_index = `RRX_IX_POINTER;
			`RRX_REG_PUSH: reg_index = `RRX_IX_PUSH;
			`RRX_REG_FILE: reg_index = `RRX_IX_FILE;
			default: reg_index = `RRX_IX_NONE;
			endcase
		end
	endfunction

	function [31:0] merge;
		input [31:0] old, nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================================
	// state
	reg state, first, carry, icyc_en;
	reg [2:0] left, last_cyc, total;
	reg [31:0] cmd;
	reg [7:0] acc, irq_control_reg, pointer_reg, div_cnt;
	reg [PC_W-1:0] pc;
	reg [6:0] win_addr;

	wire [PC_W-1:0] stack_top_entry;
	wire [SP_W-1:0] sp;
	wire [7:0] fval, win_data, rot_res, file_wdata;
	wire [3:0] wr_ix, rd_ix;
	wire [31:0] wword, acc_merged, pc_merged;
	wire [2:0] op;
	wire [6:0] eff_addr, file_waddr;
	wire wr_fire, rd_fire, cmd_go, wr_refused, sw_push;
	wire ind_hit, ind_extra, is_return, exec_now, pop;
	wire file_we_exec, file_we_sw, file_we;

	assign wr_fire = s_axi_awready & s_axi_wready;
	assign rd_fire = s_axi_arready;
	assign wr_ix = reg_index(s_axi_awaddr);
	assign rd_ix = reg_index(s_axi_araddr);
	assign wword = s_axi_wdata;
	assign acc_merged = merge({24'h00_0000, acc}, wword, s_axi_wstrb);
	assign pc_merged = merge({{(32-PC_W){1'b0}}, pc}, wword, s_axi_wstrb);
	assign wr_refused = (wr_ix == `RRX_IX_NONE) |
		((wr_ix == `RRX_IX_CMD || wr_ix == `RRX_IX_PUSH) &&
		state == ST_RUN);
	assign cmd_go = wr_fire && wr_ix == `RRX_IX_CMD && !wr_refused;
	assign sw_push = wr_fire && wr_ix == `RRX_IX_PUSH && !wr_refused;

	assign op = cmd[`RRX_F_OP];
	// indirect address redirects through the pointer
	assign ind_hit = cmd[`RRX_F_FADDR] == `RRX_INDIRECT_ADDR;
	assign eff_addr = ind_hit ? pointer_reg[6:0] : cmd[`RRX_F_FADDR];
	assign ind_extra = pointer_reg[`RRX_PTR_MSB] &
		((op == `RRX_OP_ROTATE && ind_hit) ||
		(op == `RRX_OP_GENERIC && cmd[`RRX_F_IND]));
	assign rot_res = {fval[6:0], carry};
	assign is_return = op == `RRX_OP_RETURN_FROM_IRQ || op == `RRX_OP_RETURN ||
		op == `RRX_OP_RETURN_WITH_LITERAL;
	// side effects only in the first instruction cycle
	assign exec_now = state == ST_RUN && first && icyc_en;
	assign pop = exec_now && is_return;
	assign file_we_exec = exec_now && op == `RRX_OP_ROTATE &&
		cmd[`RRX_F_DEST];
	assign file_we_sw = wr_fire && wr_ix == `RRX_IX_FILE &&
		s_axi_wstrb[0];
	assign file_we = file_we_exec | file_we_sw;
	assign file_waddr = file_we_exec ? eff_addr : wword[`RRX_F_WADDR];
	assign file_wdata = file_we_exec ? rot_res : wword[`RRX_F_WDATA];

	// ==========================================================
	// cycle count per operation
	always @* begin
		case (op)
		`RRX_OP_RETURN_FROM_IRQ: total = `RRX_CYC_TWO;
		`RRX_OP_RETURN: total = `RRX_CYC_TWO;
		`RRX_OP_RETURN_WITH_LITERAL: total = `RRX_CYC_TWO;
		`RRX_OP_ROTATE: total = `RRX_CYC_ONE + {2'b00, ind_extra};
		`RRX_OP_GENERIC: total = `RRX_CYC_ONE +
			{2'b00, cmd[`RRX_F_PCCHG] | cmd[`RRX_F_COND]} +
			{2'b00, ind_extra};
		default: total = `RRX_CYC_ONE;
		endcase
	end

	// ==========================================================
	// instruction-cycle divider
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 8'h00;
			icyc_en <= 1'b0;
		end else if (div_cnt == DIV_LAST) begin
			div_cnt <= 8'h00;
			icyc_en <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			icyc_en <= 1'b0;
		end
	end

	// ==========================================================
	// execution and architectural registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			first <= 1'b0;
			left <= 3'h0;
			last_cyc <= 3'h0;
			cmd <= `RRX_ZERO32;
			acc <= 8'h00;
			carry <= 1'b0;
			irq_control_reg <= 8'h00;
			pc <= {PC_W{1'b0}};
			pointer_reg <= 8'h00;
			win_addr <= 7'h00;
		end else begin
			if (wr_fire) begin
				case (wr_ix)
				`RRX_IX_ACC: acc <= acc_merged[7:0];
				`RRX_IX_CARRY: if (s_axi_wstrb[0]) carry <= wword[0];
				`RRX_IX_IRQCTL: if (s_axi_wstrb[0]) irq_control_reg <= wword[7:0];
				`RRX_IX_PC: pc <= pc_merged[PC_W-1:0];
				`RRX_IX_POINTER: if (s_axi_wstrb[0]) pointer_reg <= wword[7:0];
				`RRX_IX_FILE: if (s_axi_wstrb[1]) win_addr <= wword[`RRX_F_WADDR];
				default: ;
				endcase
			end
			case (state)
			ST_IDLE: begin
				if (cmd_go) begin
					cmd <= merge(cmd, wword, s_axi_wstrb);
					state <= ST_RUN;
					first <= 1'b1;
				end
			end
			ST_RUN: begin
				if (icyc_en) begin
					first <= 1'b0;
					if (first) begin
						last_cyc <= total;
						left <= total - 3'h1;
						if (total == `RRX_CYC_ONE) begin
							state <= ST_IDLE;
						end
						case (op)
						`RRX_OP_RETURN_FROM_IRQ: begin
							pc <= stack_top_entry;
							irq_control_reg[`RRX_GIE_BIT] <= 1'b1;
						end
						`RRX_OP_RETURN: pc <= stack_top_entry;
						`RRX_OP_RETURN_WITH_LITERAL: begin
							acc <= cmd[`RRX_F_LIT];
							pc <= stack_top_entry;
						end
						`RRX_OP_ROTATE: begin
							carry <= fval[7];
							if (!cmd[`RRX_F_DEST]) begin
								acc <= rot_res;
							end
							pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
						end
						`RRX_OP_GENERIC: begin
							if (!cmd[`RRX_F_PCCHG]) begin
								pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
							end
						end
						default: ;
						endcase
					end else begin
						left <= left - 3'h1;
						if (left == 3'h1) begin
							state <= ST_IDLE;
						end
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// axi4-lite write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RRX_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (!s_axi_awready && !s_axi_bvalid &&
				s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_refused ? `RRX_RESP_SLVERR : `RRX_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// axi4-lite read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RRX_RESP_OKAY;
			s_axi_rdata <= `RRX_ZERO32;
		end else begin
			s_axi_arready <= 1'b0;
			if (!s_axi_arready && !s_axi_rvalid && s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RRX_RESP_OKAY;
				s_axi_rdata <= `RRX_ZERO32;
				case (rd_ix)
				`RRX_IX_CMD: s_axi_rdata <= cmd;
				`RRX_IX_STATUS: begin
					s_axi_rdata[`RRX_S_BUSY] <= state;
					s_axi_rdata[`RRX_S_NOP] <= state & ~first;
					s_axi_rdata[`RRX_S_CYC] <= last_cyc;
					s_axi_rdata[`RRX_S_SP] <= {{(8-SP_W){1'b0}}, sp};
				end
				`RRX_IX_ACC: s_axi_rdata[7:0] <= acc;
				`RRX_IX_CARRY: s_axi_rdata[0] <= carry;
				`RRX_IX_IRQCTL: s_axi_rdata[7:0] <= irq_control_reg;
				`RRX_IX_PC: s_axi_rdata[PC_W-1:0] <= pc;
				`RRX_IX_POINTER: s_axi_rdata[7:0] <= pointer_reg;
				`RRX_IX_PUSH: s_axi_rdata[PC_W-1:0] <= stack_top_entry;
				`RRX_IX_FILE: begin
					s_axi_rdata[`RRX_F_WADDR] <= win_addr;
					s_axi_rdata[`RRX_F_WDATA] <= win_data;
				end
				default: s_axi_rresp <= `RRX_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// stack and file registers
	rrx_stack #(.DEPTH(STACK_DEPTH), .SP_W(SP_W), .AW(PC_W)) u_stack (
		.aclk(aclk), .aresetn(aresetn), .push(sw_push),
		.push_data(wword[PC_W-1:0]), .pop(pop),
		.top(stack_top_entry), .sp(sp)
	);

	rrx_file #(.DEPTH(128), .ADDR_W(7)) u_file (
		.aclk(aclk), .we(file_we), .waddr(file_waddr), .wdata(file_wdata),
		.raddr_a(eff_addr), .rdata_a(fval),
		.raddr_b(win_addr), .rdata_b(win_data)
	);

endmodule

`default_nettype wire

// ---- test/rrx_props.sv ----
/*
 checker on the register bus of the return and rotate block.
 assumes a bind onto rrx_exec with its ports unchanged.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrx_map.vh"
module rrx_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
// ====
// read address tracking
logic [7:0] ra;
always_ff @(posedge aclk)
	if (!aresetn)
		ra <= 8'h00;
	else if (s_axi_arvalid && s_axi_arready)
		ra <= s_axi_araddr;
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// ====
// assertions
a_rd_answer: assert property ($rose(s_axi_arready) |=> s_axi_rvalid)
	else $error("read answer missing");
a_wr_answer: assert property ($rose(s_axi_awready) |=>
	s_axi_bvalid && !s_axi_awready) else $error("write answer missing");
a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
	else $error("address and data ready split");
a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
a_cyc_count: assert property (
	s_axi_rvalid && ra == `RRX_REG_STATUS |-> s_axi_rdata[10:8] <= 3'h3)
	else $error("cycle count too large");
a_nop_busy: assert property (
	s_axi_rvalid && ra == `RRX_REG_STATUS && s_axi_rdata[1] |->
	s_axi_rdata[0]) else $error("no-op cycle while idle");
a_carry_one: assert property (
	s_axi_rvalid && ra == `RRX_REG_CARRY |-> s_axi_rdata[31:1] == 31'h0)
	else $error("carry wider than one bit");
a_pc_width: assert property (
	s_axi_rvalid && ra == `RRX_REG_PC |-> s_axi_rdata[31:15] == 17'h0)
	else $error("pc wider than its field");
a_bad_read: assert property (s_axi_rvalid && ra > `RRX_REG_FILE |->
	s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `RRX_RESP_SLVERR)
	else $error("unmapped read answered");
c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `RRX_RESP_SLVERR);
c_three: cover property (s_axi_rvalid && ra == `RRX_REG_STATUS &&
	s_axi_rdata[10:8] == 3'h3);
c_busy: cover property (s_axi_rvalid && ra == `RRX_REG_STATUS &&
	s_axi_rdata[0]);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
/*
 self-checking bench for the return and rotate block.
 assumes rrx_exec and rrx_props are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rrx_map.vh"
module tb;
typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} rrx_exp_t;
logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
logic awready, wready, bvalid, arready, rvalid, cr;
logic [7:0] awaddr, araddr, f, lit, av, r;
logic [6:0] fa;
logic [31:0] wdata, rdata, t;
logic [3:0] wstrb;
logic [1:0] bresp, rresp;
rrx_exp_t qr[$];
logic [1:0] qb[$];
int miscompares, checked, cyc, seed;
rrx_exec #(.CYC_DIV(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
	.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
	.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
	.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
	.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
	.s_axi_rvalid(rvalid), .s_axi_rready(rready));
initial begin
	aclk = 1'b0;
	forever #2.5 aclk = ~aclk;
end
// ====
// compare and report
task cmp_b(input logic [1:0] e, input logic [1:0] s);
	checked++;
	if (s !== e) begin
		miscompares++;
		$display("unexpected bresp: expected %h seen %h", e, s);
	end
endtask
task cmp_r(input rrx_exp_t e, input logic [31:0] d, input logic [1:0] s);
	checked++;
	if (((d & e.m) !== (e.v & e.m)) || s !== e.r) begin
		miscompares++;
		$display("unexpected rdata: expected %h/%h seen %h/%h",
			e.v & e.m, e.r, d & e.m, s);
	end
endtask
task conclude;
	$display("checked %0d miscompares %0d", checked, miscompares);
	if (miscompares == 0 && checked > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
always @(posedge aclk) begin
	if (bvalid && bready && qb.size() > 0)
		cmp_b(qb.pop_front(), bresp);
	if (rvalid && rready && qr.size() > 0)
		cmp_r(qr.pop_front(), rdata, rresp);
	cyc++;
	if (cyc == 30000) begin
		miscompares++;
		conclude();
	end
end
// ====
// bus cycles
task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
	input logic [1:0] e);
	qb.push_back(e);
	awaddr <= a;
	wdata <= d;
	wstrb <= s;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	do @(posedge aclk); while (awready !== 1'b1);
	awvalid <= 1'b0;
	wvalid <= 1'b0;
	do @(posedge aclk); while (bvalid !== 1'b1);
	bready <= 1'b0;
	@(posedge aclk);
endtask
task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
	input logic [1:0] e);
	qr.push_back('{v, m, e});
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	do @(posedge aclk); while (arready !== 1'b1);
	arvalid <= 1'b0;
	do @(posedge aclk); while (rvalid !== 1'b1);
	t = rdata;
	rready <= 1'b0;
	@(posedge aclk);
endtask
task chk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
	rd(a, v, m, `RRX_RESP_OKAY);
endtask
task st(input logic [2:0] c, input logic [7:0] sp);
	chk(`RRX_REG_STATUS, {8'h00, sp, 5'h00, c, 8'h00}, 32'h00FF_0701);
endtask
task exec(input logic [31:0] c);
	wr(`RRX_REG_CMD, c, 4'hF, `RRX_RESP_OKAY);
	do
		rd(`RRX_REG_STATUS, 32'h0000_0000, 32'h0000_0000, `RRX_RESP_OKAY);
	while (t[0] !== 1'b0);
endtask
function automatic logic [31:0] cm(input logic [2:0] op, input logic d,
	input logic [2:0] fl, input logic [6:0] a, input logic [7:0] k);
	cm = {8'h00, k, 1'b0, a, 1'b0, fl, d, op};
endfunction
// ====
// main sequence
initial begin
	seed = 95;
	{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
	{awaddr, araddr, wdata, wstrb} = 52'h0;
	repeat (6) @(posedge aclk);
	aresetn <= 1'b1;
	@(posedge aclk);
	for (int i = 0; i < 7; i++)
		chk(8'(4 * i), 32'h0000_0000, 32'hFFFF_FFFF);
	rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, `RRX_RESP_SLVERR);
	wr(8'h40, 32'h0000_00FF, 4'hF, `RRX_RESP_SLVERR);
	$display("test reset done");
	av = 8'h55;
	wr(`RRX_REG_CARRY, 1, 4'h1, `RRX_RESP_OKAY);
	wr(`RRX_REG_ACC, av, 4'hF, `RRX_RESP_OKAY);
	wr(`RRX_REG_PUSH, 32'h0000_1234, 4'hF, `RRX_RESP_OKAY);
	wr(`RRX_REG_PUSH, 32'h0000_4321, 4'hF, `RRX_RESP_OKAY);
	st(0, 2);
	wr(`RRX_REG_CMD, cm(`RRX_OP_RETURN, 0, 0, 0, 0), 4'hF, `RRX_RESP_OKAY);
	wr(`RRX_REG_PUSH, 32'h0000_0777, 4'hF, `RRX_RESP_SLVERR);
	exec(cm(`RRX_OP_GENERIC, 0, 0, 0, 0));
	wr(`RRX_REG_PUSH, 32'h0000_4321, 4'hF, `RRX_RESP_OKAY);
	exec(cm(`RRX_OP_RETURN, 0, 0, 0, 0));
	chk(`RRX_REG_PC, 32'h0000_4321, 32'h0000_7FFF);
	st(2, 1);
	chk(`RRX_REG_PUSH, 32'h0000_1234, 32'h0000_7FFF);
	lit = 8'($random(seed));
	exec(cm(`RRX_OP_RETURN_WITH_LITERAL, 0, 0, 0, lit));
	chk(`RRX_REG_ACC, lit, 32'h0000_00FF);
	chk(`RRX_REG_PC, 32'h0000_1234, 32'h0000_7FFF);
	st(2, 0);
	av = lit;
	wr(`RRX_REG_PUSH, 32'h0000_2A5A, 4'hF, `RRX_RESP_OKAY);
	exec(cm(`RRX_OP_RETURN_FROM_IRQ, 0, 0, 0, 0));
	chk(`RRX_REG_PC, 32'h0000_2A5A, 32'h0000_7FFF);
	chk(`RRX_REG_IRQCTL, 32'h0000_0080, 32'h0000_0080);
	chk(`RRX_REG_CARRY, 1, 1);
	chk(`RRX_REG_ACC, av, 32'h0000_00FF);
	st(2, 0);
	$display("test returns done");
	for (int i = 0; i < 4; i++) begin
		fa = i ? 7'({$random(seed)} % 126 + 1) : 7'h7F;
		f = 8'($random(seed));
		cr = 1'($random(seed));
		r = {f[6:0], cr};
		wr(`RRX_REG_FILE, {17'h0, fa, f}, 4'h3, `RRX_RESP_OKAY);
		wr(`RRX_REG_CARRY, cr, 4'h1, `RRX_RESP_OKAY);
		wr(`RRX_REG_PC, 32'h0000_0010, 4'hF, `RRX_RESP_OKAY);
		exec(cm(`RRX_OP_ROTATE, i[0], 0, fa, 0));
		chk(`RRX_REG_CARRY, f[7], 1);
		chk(`RRX_REG_FILE, {17'h0, fa, i[0] ? r : f}, 32'h7FFF);
		chk(`RRX_REG_ACC, i[0] ? av : r, 32'h0000_00FF);
		chk(`RRX_REG_PC, 32'h0000_0011, 32'h0000_7FFF);
		st(1, 0);
		av = i[0] ? av : r;
	end
	wr(`RRX_REG_POINTER, 32'h0000_0085, 4'h1, `RRX_RESP_OKAY);
	wr(`RRX_REG_CARRY, 0, 4'h1, `RRX_RESP_OKAY);
	wr(`RRX_REG_FILE, {17'h0, 7'h05, 8'hC3}, 4'h3, `RRX_RESP_OKAY);
	exec(cm(`RRX_OP_ROTATE, 1, 0, 0, 0));
	st(2, 0);
	chk(`RRX_REG_FILE, {17'h0, 7'h05, 8'h86}, 32'h7FFF);
	$display("test rotate done");
	for (int i = 0; i < 16; i++) begin
		wr(`RRX_REG_POINTER, i[3] ? 32'h80 : 32'h0, 4'h1, `RRX_RESP_OKAY);
		wr(`RRX_REG_PC, 32'h0000_0100, 4'hF, `RRX_RESP_OKAY);
		exec(cm(`RRX_OP_GENERIC, 0, i[2:0], 0, 0));
		st(3'(1 + (i[0] | i[1]) + (i[2] & i[3])), 0);
		if (!i[0])
			chk(`RRX_REG_PC, 32'h0000_0101, 32'h0000_7FFF);
		chk(`RRX_REG_ACC, av, 32'h0000_00FF);
	end
	$display("test cycles done");
	conclude();
end
endmodule
bind rrx_exec rrx_props chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire
